// ==== pkg/rtos_pkg.sv ====
// package: constants and types for the return-to-origin sequencer
package rtos_pkg;

    localparam logic [1:0] RTOS_MODE_TWO = 2'h0;
    localparam logic [1:0] RTOS_MODE_THREE = 2'h1;
    localparam logic [1:0] RTOS_MODE_PUSH = 2'h2;
    localparam logic [1:0] RTOS_MODE_RST = 2'h1;
    localparam logic [19:0] RTOS_SPEED_MIN = 20'h00001;
    localparam logic [19:0] RTOS_SPEED_MAX = 20'hf4240;
    localparam logic [19:0] RTOS_SEEK_SPEED_RST = 20'h003e8;
    localparam logic [19:0] RTOS_START_SPEED_RST = 20'h001f4;
    localparam logic [19:0] RTOS_ACCEL_RST = 20'h003e8;
    localparam logic [19:0] RTOS_APPROACH_LIMIT = 20'h001f4;
    localparam logic [23:0] RTOS_OFFSET_RST = 24'h000000;
    localparam logic RTOS_DIR_RST = 1'b1;
    localparam logic [9:0] RTOS_CURRENT_MAX = 10'h3e8;
    localparam logic [9:0] RTOS_CURRENT_RST = 10'h3e8;
    localparam logic [23:0] RTOS_BACKOFF_STEPS = 24'h0000c8;
    localparam logic [23:0] RTOS_HOME_POS = 24'h000000;

    typedef enum logic [2:0]
    {
        RTOS_IDLE = 3'b000,
        RTOS_SEEK = 3'b001,
        RTOS_ESCAPE = 3'b010,
        RTOS_BACKOFF = 3'b011,
        RTOS_QUALIFY = 3'b100,
        RTOS_OFFSET = 3'b101,
        RTOS_WAIT_REL = 3'b110
    } rtos_state_e;

    // configuration bundle from the host
    typedef struct packed
    {
        logic [1:0] mode;
        logic [19:0] seek_speed;
        logic [19:0] accel;
        logic [19:0] seek_start_speed;
        logic [23:0] offset;
        logic dir;
        logic sensor_input_a_en;
        logic timing_en;
        logic [9:0] push_current;
        logic [23:0] preset_pos;
    } rtos_cfg_s;

    // sensor bundle from the mechanism
    typedef struct packed
    {
        logic origin;
        logic limit_pos;
        logic limit_neg;
        logic stopper;
        logic sensor_input_a;
        logic step_timing_signal;
    } rtos_sens_s;

    // motion command towards the pulse generator
    typedef struct packed
    {
        logic run;
        logic dir;
        logic [19:0] speed;
        logic [19:0] accel;
        logic [9:0] current;
        logic current_override;
    } rtos_motion_s;

    typedef struct packed
    {
        rtos_state_e state;
        logic [5:0] sens_s1;
        logic [5:0] sens_s2;
        logic req_s1;
        logic req_s2;
        logic [23:0] steps;
        logic [23:0] cmd_pos;
        logic seek_dir;
        logic ready;
        logic complete;
        logic busy;
        rtos_motion_s motion;
    } rtos_st_s;

endpackage

// ==== hw/rtos_sequencer.sv ====
// return-to-origin sequencer: seeks home, backs off, offsets, presets position
`timescale 1ns/100ps
module rtos_sequencer
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_seek_req,
    input wire logic i_preset_req,
    input wire logic i_step,
    input wire rtos_pkg::rtos_cfg_s i_cfg,
    input wire rtos_pkg::rtos_sens_s i_sens,
    output logic o_ready,
    output logic o_seek_complete,
    output logic o_busy,
    output logic [23:0] o_cmd_pos,
    output rtos_pkg::rtos_motion_s o_motion
);

    // --------------------------------------------------------
    // state
    // --------------------------------------------------------
    rtos_pkg::rtos_st_s st_reg;
    rtos_pkg::rtos_st_s st_next;
    rtos_pkg::rtos_sens_s sens;
    logic limit_hit;
    logic qual_en;
    logic qual_ok;
    logic [19:0] approach_speed;
    logic [19:0] seek_speed;
    logic [19:0] start_speed;
    logic [19:0] accel;
    logic [9:0] push_current;
    logic [23:0] offset_mag;

    // --------------------------------------------------------
    // parameter clamps and derived values
    // --------------------------------------------------------
    always_comb
    begin
        sens = st_reg.sens_s2;
        seek_speed = i_cfg.seek_speed;
        if (seek_speed < rtos_pkg::RTOS_SPEED_MIN)
        begin
            seek_speed = rtos_pkg::RTOS_SPEED_MIN;
        end
        else if (seek_speed > rtos_pkg::RTOS_SPEED_MAX)
        begin
            seek_speed = rtos_pkg::RTOS_SPEED_MAX;
        end
        start_speed = i_cfg.seek_start_speed;
        if (start_speed < rtos_pkg::RTOS_SPEED_MIN)
        begin
            start_speed = rtos_pkg::RTOS_SPEED_MIN;
        end
        else if (start_speed > rtos_pkg::RTOS_SPEED_MAX)
        begin
            start_speed = rtos_pkg::RTOS_SPEED_MAX;
        end
        accel = i_cfg.accel;
        if (accel < rtos_pkg::RTOS_SPEED_MIN)
        begin
            accel = rtos_pkg::RTOS_SPEED_MIN;
        end
        else if (accel > rtos_pkg::RTOS_SPEED_MAX)
        begin
            accel = rtos_pkg::RTOS_SPEED_MAX;
        end
        push_current = i_cfg.push_current;
        if (push_current > rtos_pkg::RTOS_CURRENT_MAX)
        begin
            push_current = rtos_pkg::RTOS_CURRENT_MAX;
        end
        // final approach speed
        approach_speed = (start_speed < rtos_pkg::RTOS_APPROACH_LIMIT) ? start_speed
            : rtos_pkg::RTOS_APPROACH_LIMIT;
        limit_hit = st_reg.seek_dir ? sens.limit_pos : sens.limit_neg;
        qual_en = i_cfg.sensor_input_a_en | i_cfg.timing_en;
        // every enabled qualifier must be active
        qual_ok = (~i_cfg.sensor_input_a_en | sens.sensor_input_a)
            & (~i_cfg.timing_en | sens.step_timing_signal);
        offset_mag = i_cfg.offset[23] ? 24'(~i_cfg.offset + 24'h000001) : i_cfg.offset;
    end

    // --------------------------------------------------------
    // sequencer
    // --------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.sens_s1 = i_sens;
        st_next.sens_s2 = st_reg.sens_s1;
        st_next.req_s1 = i_seek_req;
        st_next.req_s2 = st_reg.req_s1;
        st_next.motion.accel = accel;
        st_next.motion.current = push_current;
        case (st_reg.state)
            rtos_pkg::RTOS_IDLE:
            begin
                st_next.motion.run = 1'b0;
                st_next.motion.current_override = 1'b0;
                st_next.busy = 1'b0;
                if (st_reg.req_s2 && st_reg.ready)
                begin
                    st_next.ready = 1'b0;
                    st_next.complete = 1'b0;
                    st_next.busy = 1'b1;
                    st_next.seek_dir = i_cfg.dir;
                    st_next.motion.run = 1'b1;
                    st_next.motion.dir = i_cfg.dir;
                    st_next.state = rtos_pkg::RTOS_SEEK;
                    case (i_cfg.mode)
                        rtos_pkg::RTOS_MODE_THREE:
                        begin
                            st_next.motion.speed = seek_speed;
                        end
                        rtos_pkg::RTOS_MODE_PUSH:
                        begin
                            st_next.motion.speed = start_speed;
                            st_next.motion.current_override = 1'b1;
                        end
                        default:
                        begin
                            st_next.motion.speed = start_speed;
                        end
                    endcase
                end
                else if (i_preset_req && st_reg.ready)
                begin
                    st_next.cmd_pos = i_cfg.preset_pos;
                end
            end
            rtos_pkg::RTOS_SEEK:
            begin
                if (i_cfg.mode == rtos_pkg::RTOS_MODE_THREE)
                begin
                    if (limit_hit)
                    begin
                        // limit met before origin: turn round and keep seeking
                        st_next.seek_dir = ~st_reg.seek_dir;
                        st_next.motion.dir = ~st_reg.seek_dir;
                    end
                    else if (sens.origin)
                    begin
                        if (qual_en)
                        begin
                            st_next.motion.speed = approach_speed;
                            st_next.state = rtos_pkg::RTOS_QUALIFY;
                        end
                        else
                        begin
                            st_next.motion.run = 1'b0;
                            st_next.cmd_pos = rtos_pkg::RTOS_HOME_POS;
                            st_next.state = rtos_pkg::RTOS_OFFSET;
                            st_next.steps = '0;
                        end
                    end
                end
                else if ((i_cfg.mode == rtos_pkg::RTOS_MODE_PUSH) ? sens.stopper : limit_hit)
                begin
                    st_next.motion.dir = ~st_reg.motion.dir;
                    st_next.motion.speed = approach_speed;
                    st_next.steps = '0;
                    st_next.state = (i_cfg.mode == rtos_pkg::RTOS_MODE_PUSH)
                        ? rtos_pkg::RTOS_BACKOFF : rtos_pkg::RTOS_ESCAPE;
                end
            end
            rtos_pkg::RTOS_ESCAPE:
            begin
                if (!(sens.limit_pos | sens.limit_neg))
                begin
                    st_next.state = rtos_pkg::RTOS_BACKOFF;
                end
            end
            rtos_pkg::RTOS_BACKOFF:
            begin
                st_next.motion.current_override = 1'b0;
                if (i_step)
                begin
                    st_next.steps = 24'(st_reg.steps + 24'h000001);
                end
                if (st_reg.steps >= rtos_pkg::RTOS_BACKOFF_STEPS)
                begin
                    st_next.steps = '0;
                    if (qual_en && i_cfg.mode == rtos_pkg::RTOS_MODE_TWO)
                    begin
                        st_next.state = rtos_pkg::RTOS_QUALIFY;
                    end
                    else
                    begin
                        st_next.motion.run = 1'b0;
                        st_next.cmd_pos = rtos_pkg::RTOS_HOME_POS;
                        st_next.state = rtos_pkg::RTOS_OFFSET;
                    end
                end
            end
            rtos_pkg::RTOS_QUALIFY:
            begin
                if (qual_ok && (i_cfg.mode != rtos_pkg::RTOS_MODE_THREE || sens.origin))
                begin
                    st_next.motion.run = 1'b0;
                    st_next.cmd_pos = rtos_pkg::RTOS_HOME_POS;
                    st_next.steps = '0;
                    st_next.state = rtos_pkg::RTOS_OFFSET;
                end
            end
            rtos_pkg::RTOS_OFFSET:
            begin
                st_next.motion.dir = ~i_cfg.offset[23];
                st_next.motion.speed = seek_speed;
                st_next.motion.run = (st_reg.steps != offset_mag);
                if (i_step && st_reg.motion.run)
                begin
                    st_next.steps = 24'(st_reg.steps + 24'h000001);
                end
                if (st_reg.steps == offset_mag)
                begin
                    st_next.motion.run = 1'b0;
                    st_next.cmd_pos = rtos_pkg::RTOS_HOME_POS;
                    st_next.complete = 1'b1;
                    st_next.state = rtos_pkg::RTOS_WAIT_REL;
                end
            end
            rtos_pkg::RTOS_WAIT_REL:
            begin
                st_next.busy = 1'b0;
                if (!st_reg.req_s2)
                begin
                    st_next.ready = 1'b1;
                    st_next.state = rtos_pkg::RTOS_IDLE;
                end
            end
            default:
            begin
                st_next.state = rtos_pkg::RTOS_IDLE;
            end
        endcase
    end

    // --------------------------------------------------------
    // registers
    // --------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (!i_rstn)
        begin
            st_reg <= '0;
            st_reg.state <= rtos_pkg::RTOS_IDLE;
            st_reg.ready <= 1'b1;
            st_reg.seek_dir <= rtos_pkg::RTOS_DIR_RST;
            st_reg.motion.dir <= rtos_pkg::RTOS_DIR_RST;
            st_reg.motion.speed <= rtos_pkg::RTOS_SEEK_SPEED_RST;
            st_reg.motion.accel <= rtos_pkg::RTOS_ACCEL_RST;
            st_reg.motion.current <= rtos_pkg::RTOS_CURRENT_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_ready = st_reg.ready;
    assign o_seek_complete = st_reg.complete;
    assign o_busy = st_reg.busy;
    assign o_cmd_pos = st_reg.cmd_pos;
    assign o_motion = st_reg.motion;

endmodule

// ==== testbench/rtos_mech_model.sv ====
// mechanism model: step pulses, stage position and sensors
`timescale 1ns/100ps
module rtos_mech_model
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_jump,
    input wire rtos_pkg::rtos_motion_s i_motion,
    output logic o_step = 1'h0,
    output rtos_pkg::rtos_sens_s o_sens,
    output int o_pos = 0
);
    int cnt = 0;
    // one step every eight cycles while the run command stands
    always @(posedge i_mclk)
    begin
        o_step <= 1'h0;
        if (!i_rstn || i_jump)
        begin
            o_pos <= 0;
            cnt <= 0;
        end
        else if (i_motion.run)
        begin
            cnt <= (cnt == 7) ? 0 : cnt + 1;
            if (cnt == 7)
            begin
                o_step <= 1'h1;
                o_pos <= o_pos + (i_motion.dir ? 1 : -1);
            end
        end
        else
            cnt <= 0;
    end
    // sensors decoded from stage position
    assign o_sens.origin = (o_pos >= 100) && (o_pos <= 120);
    assign o_sens.limit_pos = o_pos >= 300;
    assign o_sens.limit_neg = o_pos <= -300;
    assign o_sens.stopper = o_pos >= 300;
    assign o_sens.sensor_input_a = o_pos == 110;
    assign o_sens.step_timing_signal = o_pos[2:0] == 3'h6;
endmodule

// ==== testbench/rtos_sequencer_asserts.sv ====
// checker: port-level assertions for the return-to-origin sequencer
`timescale 1ns/100ps
module rtos_sequencer_asserts
(
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_seek_req,
    input wire logic i_preset_req,
    input wire logic i_step,
    input wire rtos_pkg::rtos_cfg_s i_cfg,
    input wire rtos_pkg::rtos_sens_s i_sens,
    input wire logic o_ready,
    input wire logic o_seek_complete,
    input wire logic o_busy,
    input wire logic [23:0] o_cmd_pos,
    input wire rtos_pkg::rtos_motion_s o_motion
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    property p_ack; $rose(i_seek_req) && o_ready |-> ##[1:5] (!o_ready && o_busy && o_motion.run); endproperty
    a_ack: assert property (p_ack) else $error("seek start not acknowledged");
    property p_excl; o_busy |-> !o_ready; endproperty
    a_excl: assert property (p_excl) else $error("ready high while busy");
    property p_clr; $rose(o_busy) |-> !o_seek_complete; endproperty
    a_clr: assert property (p_clr) else $error("complete not cleared at start");
    property p_done; $rose(o_seek_complete) |-> (o_cmd_pos == 24'h0) && !o_motion.run; endproperty
    a_done: assert property (p_done) else $error("complete with motion or nonzero position");
    property p_fast;
        $rose(o_busy) && (i_cfg.mode == rtos_pkg::RTOS_MODE_THREE) |-> o_motion.speed == i_cfg.seek_speed;
    endproperty
    a_fast: assert property (p_fast) else $error("wrong seek speed");
    property p_slow;
        $rose(o_busy) && (i_cfg.mode != rtos_pkg::RTOS_MODE_THREE) |-> o_motion.speed == i_cfg.seek_start_speed;
    endproperty
    a_slow: assert property (p_slow) else $error("wrong start speed");
    property p_dir; $rose(o_busy) |-> (o_motion.dir == i_cfg.dir) && (o_motion.accel == i_cfg.accel); endproperty
    a_dir: assert property (p_dir) else $error("wrong start direction or rate");
    property p_ovr;
        $rose(o_busy) && (i_cfg.mode == rtos_pkg::RTOS_MODE_PUSH) |-> o_motion.current_override;
    endproperty
    a_ovr: assert property (p_ovr) else $error("push seek without current override");
    property p_cur;
        o_motion.current_override
            |-> (o_motion.current == i_cfg.push_current) && (i_cfg.mode == rtos_pkg::RTOS_MODE_PUSH);
    endproperty
    a_cur: assert property (p_cur) else $error("wrong push current");
    property p_preset;
        o_ready && !o_busy && i_preset_req && !i_seek_req |=> o_cmd_pos == $past(i_cfg.preset_pos);
    endproperty
    a_preset: assert property (p_preset) else $error("preset not loaded");
    property p_idle; !o_busy |-> !o_motion.run; endproperty
    a_idle: assert property (p_idle) else $error("motion while idle");
    property p_approach;
        $changed(o_motion.dir) && (o_motion.dir != i_cfg.dir) && o_busy && (i_cfg.mode != rtos_pkg::RTOS_MODE_THREE)
            |-> o_motion.speed == ((i_cfg.seek_start_speed < rtos_pkg::RTOS_APPROACH_LIMIT)
            ? i_cfg.seek_start_speed : rtos_pkg::RTOS_APPROACH_LIMIT);
    endproperty
    a_approach: assert property (p_approach) else $error("wrong final approach speed");
endmodule
bind rtos_sequencer rtos_sequencer_asserts rtos_sequencer_asserts_i (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_seek_req(i_seek_req), .i_preset_req(i_preset_req), .i_step(i_step), .i_cfg(i_cfg), .i_sens(i_sens),
    .o_ready(o_ready), .o_seek_complete(o_seek_complete), .o_busy(o_busy), .o_cmd_pos(o_cmd_pos), .o_motion(o_motion));

// ==== testbench/test_return_to_origin_sequencer.sv ====
// self-checking bench for the return-to-origin sequencer
`timescale 1ns/100ps
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t %s", $time, m); end end
module test_return_to_origin_sequencer;
    typedef struct {logic [23:0] cmd; int pos;} rtos_exp_s;
    logic mclk = 1'h0, rstn = 1'h0, seek_req = 1'h0, preset_req = 1'h0, jump = 1'h0;
    logic step, ready, done, busy, prev_done = 1'h0;
    logic [23:0] cmd_pos, prev_pos = 24'h0;
    logic [31:0] seed = 32'h11, v;
    rtos_pkg::rtos_cfg_s cfg;
    rtos_pkg::rtos_sens_s sens;
    rtos_pkg::rtos_motion_s motion;
    int pos, fail_count = 0, n_checks = 0;
    rtos_exp_s exp_q[$];
    rtos_exp_s e;
    always #50 mclk = ~mclk;
    rtos_sequencer rtos_sequencer_i (.i_mclk(mclk), .i_rstn(rstn), .i_seek_req(seek_req), .i_preset_req(preset_req),
        .i_step(step), .i_cfg(cfg), .i_sens(sens), .o_ready(ready), .o_seek_complete(done), .o_busy(busy),
        .o_cmd_pos(cmd_pos), .o_motion(motion));
    rtos_mech_model rtos_mech_model_i (.i_mclk(mclk), .i_rstn(rstn), .i_jump(jump), .i_motion(motion),
        .o_step(step), .o_sens(sens), .o_pos(pos));
    function automatic logic [31:0] xrand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task stop_test;
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task wait_for(input logic want, input int lim, input string m);
        int k;
        k = 0;
        while (((m == "done") ? done : ready) !== want && k < lim)
        begin
            @(posedge mclk) #1 k++;
        end
        if (k >= lim)
        begin
            fail_count++;
            $display("BAD %0t wait for %s timed out", $time, m);
        end
    endtask
    // ----------------------------------------
    // one complete seek with fresh random speeds
    // ----------------------------------------
    task seek(input logic [1:0] m, input logic d, s, t, input logic [23:0] off, input int exp_pos);
        @(posedge mclk) #1 jump = 1'h1;
        cfg.mode = m;
        cfg.dir = d;
        cfg.sensor_input_a_en = s;
        cfg.timing_en = t;
        cfg.offset = off;
        cfg.seek_speed = 20'(xrand() % 1000000 + 1);
        cfg.seek_start_speed = 20'(xrand() % 1000000 + 1);
        cfg.accel = 20'(xrand() % 1000000 + 1);
        cfg.push_current = 10'(xrand() % 1001);
        @(posedge mclk) #1 jump = 1'h0;
        exp_q.push_back('{24'h0, exp_pos});
        wait_for(1'h1, 100, "ready");
        seek_req = 1'h1;
        wait_for(1'h0, 100, "ready");
        seek_req = 1'h0;
        wait_for(1'h1, 20000, "done");
        wait_for(1'h1, 100, "ready");
    endtask
    // ----------------------------------------
    // result monitor
    // ----------------------------------------
    // sampled on the falling edge, away from the edge that launches the outputs
    always @(negedge mclk)
    begin
        prev_done <= done;
        prev_pos <= cmd_pos;
        if (rstn && ((done && !prev_done) || (!busy && cmd_pos !== prev_pos)))
        begin
            if (exp_q.size() == 0)
            begin
                fail_count++;
                $display("BAD %0t unexpected result", $time);
            end
            else
            begin
                e = exp_q.pop_front();
                `CHK(cmd_pos, e.cmd, "command position")
                if (e.pos != -1) `CHK(pos, e.pos, "stop position")
            end
        end
    end
    initial
    begin
        #(100 * 60000);
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        stop_test;
    end
    initial
    begin
        cfg = '{rtos_pkg::RTOS_MODE_RST, rtos_pkg::RTOS_SEEK_SPEED_RST, rtos_pkg::RTOS_ACCEL_RST,
            rtos_pkg::RTOS_START_SPEED_RST, rtos_pkg::RTOS_OFFSET_RST, rtos_pkg::RTOS_DIR_RST, 1'h0, 1'h0,
            rtos_pkg::RTOS_CURRENT_RST, 24'h0};
        repeat (8) @(posedge mclk);
        #1 rstn = 1'h1;
        `CHK({ready, done, busy, motion.run}, 4'h8, "reset outputs")
        `CHK({motion.dir, motion.speed, cmd_pos}, {1'h1, 20'h3e8, 24'h0}, "reset motion")
        seek(rtos_pkg::RTOS_MODE_THREE, 1'h1, 1'h0, 1'h0, 24'h0, 100);
        seek(rtos_pkg::RTOS_MODE_THREE, 1'h1, 1'h0, 1'h0, 24'h5, 105);
        seek(rtos_pkg::RTOS_MODE_THREE, 1'h1, 1'h0, 1'h0, 24'hfffffd, 97);
        seek(rtos_pkg::RTOS_MODE_THREE, 1'h0, 1'h0, 1'h0, 24'h0, 100);
        seek(rtos_pkg::RTOS_MODE_THREE, 1'h1, 1'h1, 1'h0, 24'h0, 110);
        seek(rtos_pkg::RTOS_MODE_THREE, 1'h1, 1'h0, 1'h1, 24'h0, 102);
        seek(rtos_pkg::RTOS_MODE_THREE, 1'h1, 1'h1, 1'h1, 24'h0, 110);
        seek(rtos_pkg::RTOS_MODE_TWO, 1'h1, 1'h0, 1'h0, 24'h0, 99);
        seek(rtos_pkg::RTOS_MODE_PUSH, 1'h1, 1'h1, 1'h0, 24'h0, 100);
        // back-to-back presets while stopped
        repeat (2)
        begin
            @(posedge mclk) #1 v = xrand();
            cfg.preset_pos = v[23:0];
            preset_req = 1'h1;
            exp_q.push_back('{v[23:0], -1});
        end
        @(posedge mclk) #1 preset_req = 1'h0;
        repeat (4) @(posedge mclk);
        `CHK(exp_q.size(), 0, "results missing")
        stop_test;
    end
endmodule
